// File: include/phy_cfg_pkg.sv
// Functional notes
// - Slew pins load default of slew field
// - Strap pins give port 0 address, lsb zero
// - Port 1 address is port 0 plus one
// - Fiber uses signal detect; copper holds it low
// - Fiber transmits on pair B, receives on A
package phy_cfg_pkg;

    // Register offsets (Wishbone byte addresses)
    localparam logic [7:0] REG_GLOBAL_OFS = 8'h00;   // Slew field, software reset
    localparam logic [7:0] REG_PORT0_OFS  = 8'h04;   // Port 0 control and status
    localparam logic [7:0] REG_PORT1_OFS  = 8'h08;   // Port 1 control and status
    localparam logic [7:0] REG_ADDR_OFS   = 8'h0C;   // Management addresses

    // Global register fields
    localparam int SLEW_LSB    = 10;                 // Slew field low bit
    localparam int SLEW_MSB    = 11;                 // Slew field high bit
    localparam int SWRST_BIT   = 15;                 // Software reset bit

    // Port register fields
    localparam int FIBER_BIT   = 0;                  // Fiber mode select
    localparam int SPEED_BIT   = 1;                  // Speed status
    localparam int LINK_BIT    = 2;                  // Link status
    localparam int DUPLEX_BIT  = 3;                  // Duplex status
    localparam int SIGDET_BIT  = 8;                  // Signal detect readback
    localparam int TXPAIR_BIT  = 9;                  // Transmit pair is B
    localparam int RXPAIR_BIT  = 10;                 // Receive pair is B
    localparam int IND_LSB     = 12;                 // Indicator readback low bit

    // Address register fields
    localparam int MGMT_PORT_ADDR_STRAP_B1_LSB   = 8;                  // Port 1 address low bit

    localparam logic [1:0] SLEW_RST = 2'h0;          // Slew reset before strap load
    localparam logic       ADDR_LSB_P0 = 1'b0;       // Port 0 address bit 0
    localparam logic [4:0] ADDR_STEP   = 5'h01;      // Port 1 address offset

    localparam int REF_CLK_MHZ = 25;                 // Reference clock rate

    // Indicator map choices, encoded {sel1, sel0}
    typedef enum logic [1:0] {
        MAP_BASIC    = 2'h0,
        MAP_ACTIVITY = 2'h1,
        MAP_TRAFFIC  = 2'h2,
        MAP_ISOLATE  = 2'h3
    } ind_map_t;

    // Per-port live status
    typedef struct packed {
        logic speed;
        logic link;
        logic duplex;
        logic activity;
        logic collision;
        logic rx_act;
        logic tx_act;
        logic isolate;
    } port_stat_t;

    // Classic Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// File: core/indicator_mux.sv
`timescale 1ns/1ps
`default_nettype none
module indicator_mux (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire phy_cfg_pkg::ind_map_t    map_i,
    input  wire phy_cfg_pkg::port_stat_t  stat_i,
    output logic [2:0]                    ind_o
);
    import phy_cfg_pkg::*;

    logic [2:0] ind_d;   // Next indicator levels
    logic [2:0] ind_q;   // Registered indicator levels

    // Pick the status shown on each of the three indicators
    always_comb begin
        case (map_i)
            MAP_BASIC:    ind_d = {stat_i.duplex, stat_i.link, stat_i.speed};
            MAP_ACTIVITY: ind_d = {stat_i.duplex | stat_i.collision,
                                   stat_i.link | stat_i.activity, stat_i.speed};
            MAP_TRAFFIC:  ind_d = {stat_i.tx_act, stat_i.rx_act, stat_i.link};
            MAP_ISOLATE:  ind_d = {stat_i.duplex | stat_i.collision,
                                   stat_i.link | stat_i.isolate, stat_i.speed};
            default:      ind_d = 3'h0;
        endcase
    end

    // Register the indicators
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ind_q <= 3'h0;
        end else begin
            ind_q <= ind_d;
        end
    end

    assign ind_o = ind_q;
endmodule
`default_nettype wire

// File: core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0]      sync_o
);
    logic [WIDTH-1:0] meta_q;   // First stage, read only by second
    logic [WIDTH-1:0] sync_q;   // Second stage

    // Two-flop synchroniser
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: core/phy_global_strap_config.sv
`timescale 1ns/1ps
`default_nettype none
module phy_global_strap_config (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    input  wire logic                    reset_pin_n_i,
    input  wire logic                    tx_edge_rate_sel_lo_i,
    input  wire logic                    tx_edge_rate_sel_hi_i,
    input  wire logic [3:0]              mgmt_port_addr_strap_i,
    input  wire logic                    indicator_map_sel0_i,
    input  wire logic                    indicator_map_sel1_i,
    input  wire logic [1:0]              fiber_sig_detect_i,
    input  wire phy_cfg_pkg::port_stat_t stat_p0_i,
    input  wire phy_cfg_pkg::port_stat_t stat_p1_i,
    input  wire phy_cfg_pkg::wb_req_t    wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         core_reset_o,
    output logic [1:0]                   tx_slew_o,
    output logic [4:0]                   mgmt_addr_p0_o,
    output logic [4:0]                   mgmt_addr_p1_o,
    output logic [1:0]                   fiber_mode_o,
    output logic [1:0]                   sig_quality_o,
    output logic [1:0]                   tx_on_pair_b_o,
    output logic [1:0]                   rx_on_pair_b_o,
    output logic [2:0]                   indicator_p0_o,
    output logic [2:0]                   indicator_p1_o
);
    import phy_cfg_pkg::*;

    // Synchronised pins
    logic [1:0] slew_s;     // Slew strap pins
    logic [3:0] addr_s;     // Address strap pins
    logic [1:0] map_s;      // Indicator map pins
    logic [1:0] sd_s;       // Signal detect pins
    logic       rstn_s;     // Reset pin, active low

    pin_sync #(.WIDTH(11)) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  ({tx_edge_rate_sel_hi_i, tx_edge_rate_sel_lo_i, mgmt_port_addr_strap_i,
                  indicator_map_sel1_i, indicator_map_sel0_i, fiber_sig_detect_i, reset_pin_n_i}),
        .sync_o ({slew_s, addr_s, map_s, sd_s, rstn_s})
    );

    // Register state
    logic [1:0] slew_q,  slew_d;    // Slew field
    logic       swrst_q, swrst_d;   // Software reset bit
    logic [1:0] fiber_q, fiber_d;   // Per-port fiber mode
    logic [3:0] addr_q,  addr_d;    // Latched address straps
    logic       load_q,  load_d;    // Strap load pending
    logic       ack_q,   ack_d;     // Wishbone acknowledge
    logic [31:0] dat_q,  dat_d;     // Read data
    logic       crst_q,  crst_d;    // Combined reset

    logic       hit;                // Bus access this cycle
    logic       wr;                 // Write strobe
    logic       any_rst;            // Combined reset condition

    // Combined reset from pin or software bit; bus reset acts only through the register reset
    assign any_rst = !rstn_s || swrst_q;

    // Build one port's readback word
    function automatic logic [31:0] port_word(input logic fib, input logic sd, input logic [2:0] ind,
                                              input port_stat_t st);
        logic [31:0] w;
        w = 32'h0;
        w[FIBER_BIT]  = fib;
        w[SPEED_BIT]  = st.speed;
        w[LINK_BIT]   = st.link;
        w[DUPLEX_BIT] = st.duplex;
        w[SIGDET_BIT] = sd;
        w[TXPAIR_BIT] = fib;
        w[RXPAIR_BIT] = 1'b0;
        w[IND_LSB +: 3] = ind;
        return w;
    endfunction

    assign hit = wb_req_i.cyc && wb_req_i.stb && !ack_q;
    assign wr  = hit && wb_req_i.we;

    // Next register values and bus answer
    always_comb begin
        slew_d  = slew_q;
        swrst_d = 1'b0;
        fiber_d = fiber_q;
        addr_d  = addr_q;
        load_d  = 1'b0;
        ack_d   = hit;
        dat_d   = 32'h0;
        crst_d  = any_rst;
        if (load_q) begin
            slew_d = slew_s;
            addr_d = addr_s;
        end
        if (wr) begin
            case (wb_req_i.adr)
                REG_GLOBAL_OFS: begin
                    if (wb_req_i.sel[1]) begin
                        slew_d  = wb_req_i.dat[SLEW_MSB:SLEW_LSB];
                        swrst_d = wb_req_i.dat[SWRST_BIT];
                    end
                end
                REG_PORT0_OFS: begin
                    if (wb_req_i.sel[0]) begin
                        fiber_d[0] = wb_req_i.dat[FIBER_BIT];
                    end
                end
                REG_PORT1_OFS: begin
                    if (wb_req_i.sel[0]) begin
                        fiber_d[1] = wb_req_i.dat[FIBER_BIT];
                    end
                end
                default: begin
                    dat_d = 32'h0;      // Unmapped writes ignored
                end
            endcase
        end
        if (hit && !wb_req_i.we) begin
            case (wb_req_i.adr)
                REG_GLOBAL_OFS: begin
                    dat_d[SLEW_MSB:SLEW_LSB] = slew_q;
                    dat_d[SWRST_BIT]         = swrst_q;
                end
                REG_PORT0_OFS: dat_d = port_word(fiber_q[0], sig_quality_o[0], indicator_p0_o, stat_p0_i);
                REG_PORT1_OFS: dat_d = port_word(fiber_q[1], sig_quality_o[1], indicator_p1_o, stat_p1_i);
                REG_ADDR_OFS: begin
                    dat_d[4:0]               = mgmt_addr_p0_o;
                    dat_d[MGMT_PORT_ADDR_STRAP_B1_LSB +: 5]    = mgmt_addr_p1_o;
                end
                default: dat_d = 32'h0; // Unmapped reads return zero
            endcase
        end
        if (any_rst) begin
            load_d  = 1'b1;            // Reload straps on release
            fiber_d = 2'h0;
        end
    end

    // Register all state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            slew_q  <= SLEW_RST;
            swrst_q <= 1'b0;
            fiber_q <= 2'h0;
            addr_q  <= 4'h0;
            load_q  <= 1'b1;
            ack_q   <= 1'b0;
            dat_q   <= 32'h0;
            crst_q  <= 1'b1;
        end else begin
            slew_q  <= slew_d;
            swrst_q <= swrst_d;
            fiber_q <= fiber_d;
            addr_q  <= addr_d;
            load_q  <= load_d;
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            crst_q  <= crst_d;
        end
    end

    // Indicator mapping per port
    indicator_mux u_ind0 (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .map_i  (ind_map_t'({map_s[1], map_s[0]})),
        .stat_i (stat_p0_i),
        .ind_o  (indicator_p0_o)
    );
    indicator_mux u_ind1 (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .map_i  (ind_map_t'({map_s[1], map_s[0]})),
        .stat_i (stat_p1_i),
        .ind_o  (indicator_p1_o)
    );

    assign wb_dat_o       = dat_q;
    assign wb_ack_o       = ack_q;
    assign core_reset_o   = crst_q;
    assign tx_slew_o      = slew_q;
    assign mgmt_addr_p0_o = {addr_q, ADDR_LSB_P0};
    assign mgmt_addr_p1_o = mgmt_addr_p0_o + ADDR_STEP;
    assign fiber_mode_o   = fiber_q;
    assign sig_quality_o  = sd_s & fiber_q;
    assign tx_on_pair_b_o = fiber_q;
    assign rx_on_pair_b_o = 2'h0;
endmodule
`default_nettype wire

// File: tb/phy_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_checker
    import phy_cfg_pkg::*;
(
    input wire logic                    mclk_i,
    input wire logic                    rst_i,
    input wire logic                    reset_pin_n_i,
    input wire phy_cfg_pkg::wb_req_t    wb_req_i,
    input wire logic                    wb_ack_o,
    input wire logic                    core_reset_o,
    input wire logic [4:0]              mgmt_addr_p0_o,
    input wire logic [4:0]              mgmt_addr_p1_o,
    input wire logic [1:0]              fiber_mode_o,
    input wire logic [1:0]              sig_quality_o,
    input wire logic [1:0]              tx_on_pair_b_o,
    input wire logic [1:0]              rx_on_pair_b_o
);
    // One clock domain, bus reset disables all checks
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_addr_lsb_zero: assert property (mgmt_addr_p0_o[0] == 1'h0)
        else $error("port 0 address bit 0 is set");
    a_addr_step_one: assert property (!core_reset_o && !$past(core_reset_o) && !$past(core_reset_o, 2)
        |-> mgmt_addr_p1_o == mgmt_addr_p0_o + 5'h01)
        else $error("port 1 address is not port 0 plus one");
    a_ack_follows_req: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_pin_resets: assert property (!reset_pin_n_i |-> ##[1:4] core_reset_o)
        else $error("reset pin did not reset the core");
    a_bus_reset_held: assert property ($past(rst_i) |-> core_reset_o)
        else $error("core reset low right after bus reset");
    a_pair_roles: assert property (tx_on_pair_b_o == fiber_mode_o && rx_on_pair_b_o == 2'h0)
        else $error("pair roles do not follow fiber mode");
    a_quality_gate: assert property ((sig_quality_o & ~(fiber_mode_o | $past(fiber_mode_o))) == 2'h0)
        else $error("signal quality shown on a copper port");

    // Main scenarios reached
    c_bus_write: cover property (wb_ack_o && wb_req_i.we);
    c_quality: cover property (|sig_quality_o);
    c_reset_end: cover property ($fell(core_reset_o));
endmodule
bind phy_global_strap_config phy_cfg_checker phy_cfg_checker_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .reset_pin_n_i(reset_pin_n_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .core_reset_o(core_reset_o),
    .mgmt_addr_p0_o(mgmt_addr_p0_o), .mgmt_addr_p1_o(mgmt_addr_p1_o), .fiber_mode_o(fiber_mode_o),
    .sig_quality_o(sig_quality_o), .tx_on_pair_b_o(tx_on_pair_b_o), .rx_on_pair_b_o(rx_on_pair_b_o));
`default_nettype wire

// File: tb/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic       mclk_i,
    input  wire logic [1:0] fiber_i,
    input  wire logic [1:0] sd_req_i,
    input  wire logic [9:0] strap_req_i,
    output logic [1:0]      sd_o,
    output logic [9:0]      strap_o
);
    localparam logic [1:0] TEST_PINS = 2'h0;
    // Straps as {map sel1, sel0, slew hi, lo, addr 4:1}
    always_ff @(posedge mclk_i) begin
        strap_o <= strap_req_i;
        sd_o    <= sd_req_i & fiber_i & ~TEST_PINS;
    end
endmodule
`default_nettype wire

// File: tb/phy_global_strap_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module phy_global_strap_config_tb;
    import phy_cfg_pkg::*;
    logic        mclk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        reset_pin_n_i = 1'h1;
    logic [1:0]  sd_req = 2'h0, sd, tx_slew_o, fiber_mode_o, sig_quality_o, tx_on_pair_b_o, rx_on_pair_b_o;
    logic [9:0]  strap_req = 10'h000, strap;
    port_stat_t  st0 = '0, st1 = '0;
    wb_req_t     req = '0;
    logic [31:0] wb_dat_o, rnd = 32'h9, exp_q[$];
    logic        wb_ack_o, core_reset_o;
    logic [4:0]  mgmt_addr_p0_o, mgmt_addr_p1_o;
    logic [2:0]  indicator_p0_o, indicator_p1_o;
    int          err_count = 0, cmp_count = 0, cycles = 0;

    phy_global_strap_config phy_global_strap_config_i (.mclk_i(mclk_i), .rst_i(rst_i),
        .reset_pin_n_i(reset_pin_n_i), .tx_edge_rate_sel_lo_i(strap[4]), .tx_edge_rate_sel_hi_i(strap[5]),
        .mgmt_port_addr_strap_i(strap[3:0]), .indicator_map_sel0_i(strap[6]), .indicator_map_sel1_i(strap[7]),
        .fiber_sig_detect_i(sd), .stat_p0_i(st0), .stat_p1_i(st1), .wb_req_i(req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_reset_o(core_reset_o), .tx_slew_o(tx_slew_o),
        .mgmt_addr_p0_o(mgmt_addr_p0_o), .mgmt_addr_p1_o(mgmt_addr_p1_o), .fiber_mode_o(fiber_mode_o),
        .sig_quality_o(sig_quality_o), .tx_on_pair_b_o(tx_on_pair_b_o), .rx_on_pair_b_o(rx_on_pair_b_o),
        .indicator_p0_o(indicator_p0_o), .indicator_p1_o(indicator_p1_o));
    board_model board_model_i (.mclk_i(mclk_i), .fiber_i(fiber_mode_o), .sd_req_i(sd_req),
        .strap_req_i(strap_req), .sd_o(sd), .strap_o(strap));

    // Stand-in for the board reference clock
    initial forever #2 mclk_i = ~mclk_i;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Indicators {third, second, first} for map {sel1, sel0}
    function automatic logic [2:0] ind_exp(input logic [1:0] m, input port_stat_t s);
        case (m)
            2'h0: return {s.duplex, s.link, s.speed};
            2'h1: return {s.duplex | s.collision, s.link | s.activity, s.speed};
            2'h2: return {s.tx_act, s.rx_act, s.link};
            default: return {s.duplex | s.collision, s.link | s.isolate, s.speed};
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Classic single cycle; reads note their expected data
    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d,
                      input logic [31:0] e);
        @(posedge mclk_i);
        req <= '{cyc: 1'h1, stb: 1'h1, we: w, sel: s, adr: a, dat: d};
        if (!w)
            exp_q.push_back(e);
        do @(posedge mclk_i); while (wb_ack_o !== 1'h1);
        req <= '0;
        @(posedge mclk_i);
    endtask

    // Read data taken at the acknowledging edge
    always @(posedge mclk_i) begin
        if (wb_ack_o === 1'h1 && req.cyc === 1'h1 && req.we === 1'h0) begin
            if (exp_q.size() == 0)
                check("read queue", 32'h1, 32'h0);
            else
                check("read data", wb_dat_o, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'h0;
        // New straps and status, then a reset pin pulse, once per map
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            strap_req <= {2'h0, i[1:0], rnd[5:0]};
            st0 <= rnd[15:8];
            st1 <= rnd[23:16];
            repeat (4) @(posedge mclk_i);
            reset_pin_n_i <= 1'h0;
            @(posedge mclk_i);
            reset_pin_n_i <= 1'h1;
            repeat (12) @(posedge mclk_i);
            check("core reset", core_reset_o, 32'h0);
            check("slew", tx_slew_o, strap_req[5:4]);
            check("addr p0", mgmt_addr_p0_o, {strap_req[3:0], 1'h0});
            check("addr p1", mgmt_addr_p1_o, {strap_req[3:0], 1'h1});
            check("ind p0", indicator_p0_o, ind_exp(strap_req[7:6], st0));
            check("ind p1", indicator_p1_o, ind_exp(strap_req[7:6], st1));
            wb(REG_ADDR_OFS, 1'h0, 4'hF, 32'h0, {19'h0, strap_req[3:0], 4'h8, strap_req[3:0], 1'h0});
        end
        wb(8'h10, 1'h0, 4'hF, 32'h0, 32'h0);
        // Port 0 to fiber with light on both ports
        sd_req <= 2'h3;
        wb(REG_PORT0_OFS, 1'h1, 4'h1, 32'h1, 32'h0);
        repeat (6) @(posedge mclk_i);
        check("fiber", fiber_mode_o, 2'h1);
        check("tx pair", tx_on_pair_b_o, 2'h1);
        check("rx pair", rx_on_pair_b_o, 2'h0);
        check("quality", sig_quality_o, 2'h1);
        wb(REG_GLOBAL_OFS, 1'h1, 4'h2, 32'h00000C00, 32'h0);
        repeat (2) @(posedge mclk_i);
        check("slew write", tx_slew_o, 2'h3);
        // Software reset restores strap slew and copper mode
        wb(REG_GLOBAL_OFS, 1'h1, 4'h2, 32'h00008000, 32'h0);
        repeat (10) @(posedge mclk_i);
        check("swrst fiber", fiber_mode_o, 2'h0);
        check("swrst slew", tx_slew_o, strap_req[5:4]);
        results();
    end
endmodule
`default_nettype wire
